//--- lpm_defines.svh
// Timing counts and the counter width for the low-power mode controller.
// Assumes a 100 MHz system clock standing in for the oscillator.
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// Oscillator restart settle time after stop mode, in ns.
`define LPM_OSC_SETTLE_NS      20000
`define LPM_CLK_PERIOD_NS      10
`define LPM_OSC_SETTLE_CYC     ((`LPM_OSC_SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
// Width of the settle counter.
`define LPM_CNT_W              16
// Internal clock is the system clock divided by two.
`define LPM_PHI_DIV            2

`endif

//--- lpm_pkg.sv
// Types for the low-power mode controller.
// Assumes lpm_defines.svh is available on the include path.
`default_nettype none
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_RUN  = 2'b00,
    LPM_WAIT = 2'b01,
    LPM_STOP = 2'b11,
    LPM_SETL = 2'b10
  } lpm_state_t;
endpackage
`default_nettype wire

//--- lpm_gate_if.sv
// Interface between the mode controller and its clock gate.
// Assumes both ends share clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
interface lpm_gate_if;
  logic run_req;
  logic phi_low;
  logic phi_en;
  modport ctrl (output run_req, input phi_low, input phi_en);
  modport gate (input run_req, output phi_low, output phi_en);
endinterface
`default_nettype wire

//--- lpm_clk_gate.sv
// Internal clock divider with glitch-free gating.
// Assumes one system clock; the internal clock is a registered divide-by-two.
`timescale 1ns/1ps
`default_nettype none
module lpm_clk_gate (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Control side
  lpm_gate_if.gate  gate_if,
  // Internal clock out
  output logic      phi_o
);
  typedef struct packed {
    logic phi;
    logic on;
  } lpm_gate_t;

  lpm_gate_t st_reg;
  lpm_gate_t st_next;

  // The enable only changes while the internal clock sits low.
  always_comb begin
    st_next = st_reg;
    if (!st_reg.phi) begin
      st_next.on = gate_if.run_req;
    end
    st_next.phi = st_next.on & ~st_reg.phi;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phi_o           = st_reg.phi;
  assign gate_if.phi_low = ~st_reg.phi;
  // One-cycle enable on each rising internal clock edge.
  assign gate_if.phi_en  = st_next.phi & ~st_reg.phi;
endmodule
`default_nettype wire

//--- lpm_ctrl.sv
// Low-power mode controller: wait and stop instruction handling.
// Assumes the core decodes wait_instruction and stop_instruction as one-cycle pulses.
// Functional notes
// - A wait instruction enters wait mode with the internal clock held low and the oscillator on.
// - A stop instruction enters stop mode, halting the oscillator with the internal clock low.
// - Leaving wait mode resumes execution at once with no settle delay.
// - Leaving stop mode waits for the restarted oscillator to settle before running.
// - In wait mode the peripheral clock keeps running so peripherals can interrupt.
// - A wait executed from internal RAM leaves the external chip selects deasserted.
// - An enabled interrupt ends wait mode and is serviced; a later wait re-enters it.
`include "lpm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl #(
  parameter int unsigned SETTLE_CYC = `LPM_OSC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Instruction decode
  input  wire logic wait_instruction_i,
  input  wire logic stop_instruction_i,
  input  wire logic fetch_internal_i,
  // External bus requests from the core
  input  wire logic ext_cs_req_i,
  input  wire logic ram_cs_req_i,
  // Interrupts
  input  wire logic irq_pending_i,
  // Clocks and status
  output logic      phi_o,
  output logic      periph_en_o,
  output logic      osc_run_o,
  output logic      wake_o,
  output logic      sleep_o,
  // Chip selects, active low
  output logic      ext_cs_n_o,
  output logic      ram_chip_select_n_o
);
  typedef struct packed {
    lpm_pkg::lpm_state_t     mode;
    logic [`LPM_CNT_W-1:0]   cnt;
    logic                    wake;
    logic                    ext_cs_n;
    logic                    ram_cs_n;
  } lpm_ctrl_st_t;

  lpm_ctrl_st_t st_reg;
  lpm_ctrl_st_t st_next;
  lpm_gate_if   gate_if ();

  localparam logic [`LPM_CNT_W-1:0] SETTLE_LAST = `LPM_CNT_W'(SETTLE_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next      = st_reg;
    st_next.wake = 1'b0;
    unique case (st_reg.mode)
      lpm_pkg::LPM_RUN: begin
        if (stop_instruction_i) begin
          st_next.mode = lpm_pkg::LPM_STOP;
        end else if (wait_instruction_i) begin
          st_next.mode = lpm_pkg::LPM_WAIT;
        end
      end
      lpm_pkg::LPM_WAIT: begin
        if (irq_pending_i) begin
          st_next.mode = lpm_pkg::LPM_RUN;
          st_next.wake = 1'b1;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (irq_pending_i) begin
          st_next.mode = lpm_pkg::LPM_SETL;
          st_next.cnt  = '0;
        end
      end
      lpm_pkg::LPM_SETL: begin
        if (st_reg.cnt == SETTLE_LAST) begin
          st_next.mode = lpm_pkg::LPM_RUN;
          st_next.wake = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + `LPM_CNT_W'(1);
        end
      end
    endcase
    // Chip selects drop while asleep or when the core runs from internal RAM.
    if (st_next.mode != lpm_pkg::LPM_RUN || fetch_internal_i) begin
      st_next.ext_cs_n = 1'b1;
      st_next.ram_cs_n = 1'b1;
    end else begin
      st_next.ext_cs_n = ~ext_cs_req_i;
      st_next.ram_cs_n = ~ram_cs_req_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg          <= '0;
      st_reg.mode     <= lpm_pkg::LPM_RUN;
      st_reg.ext_cs_n <= 1'b1;
      st_reg.ram_cs_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign gate_if.run_req = (st_reg.mode == lpm_pkg::LPM_RUN);

  lpm_clk_gate u_gate (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .gate_if   (gate_if),
    .phi_o     (phi_o)
  );

  // Peripherals keep their tick in wait mode; stop mode and the settle wait silence them.
  assign periph_en_o         = osc_run_o;
  assign osc_run_o           = (st_reg.mode != lpm_pkg::LPM_STOP) &&
                               (st_reg.mode != lpm_pkg::LPM_SETL);
  assign wake_o              = st_reg.wake;
  assign sleep_o             = ~gate_if.run_req;
  assign ext_cs_n_o          = st_reg.ext_cs_n;
  assign ram_chip_select_n_o = st_reg.ram_cs_n;
endmodule
`default_nettype wire

//--- lpm_irq_model.sv
// Interrupt source model for the low-power mode controller.
// Assumes the bench pulses fire_i and the block pulses wake_i.
`timescale 1ns/1ps
`default_nettype none
module lpm_irq_model (
  // Clock, reset and control
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic fire_i,
  input  wire logic wake_i,
  // Request
  output logic      irq_pending_o
);
  // The request stays up as a level until the block reports wake-up.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) irq_pending_o <= 1'b0;
    else if (wake_i) irq_pending_o <= 1'b0;
    else if (fire_i) irq_pending_o <= 1'b1;
  end
endmodule
`default_nettype wire

//--- lpm_ctrl_checker.sv
// Port assertions for the low-power mode controller.
// Assumes binding onto lpm_ctrl with its settle parameter.
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_checker #(parameter int unsigned SETTLE_CYC = 4) (
  // Watched ports
  input wire logic clk_sys_i, arst_n_i, wait_instruction_i, stop_instruction_i,
  input wire logic fetch_internal_i, irq_pending_i, phi_o, periph_en_o, osc_run_o,
  input wire logic wake_o, sleep_o, ext_cs_n_o, ram_chip_select_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic [31:0] n_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) n_reg <= '0;
    else n_reg <= (!osc_run_o && irq_pending_i) ? n_reg + 32'h1 : 32'h0;
  end
  a_wait_enters: assert property (wait_instruction_i && !stop_instruction_i && !sleep_o
    |=> sleep_o && periph_en_o) else $error("wait not entered");
  a_phi_low: assert property (sleep_o [*2] |-> !phi_o) else $error("clock not low");
  a_stop_osc_off: assert property (stop_instruction_i && !sleep_o
    |=> sleep_o && !osc_run_o) else $error("oscillator still on");
  a_periph_on: assert property (osc_run_o |-> periph_en_o) else $error("periph off");
  a_wait_exit: assert property (sleep_o && osc_run_o && irq_pending_i
    |=> wake_o && !sleep_o) else $error("slow wait exit");
  a_settle_len: assert property (wake_o && !$past(osc_run_o)
    |-> n_reg == SETTLE_CYC + 1) else $error("bad settle time");
  a_cs_internal: assert property (fetch_internal_i
    |=> ext_cs_n_o && ram_chip_select_n_o) else $error("select on internal");
  a_cs_asleep: assert property (sleep_o |-> ext_cs_n_o && ram_chip_select_n_o)
    else $error("select on asleep");
endmodule
bind lpm_ctrl lpm_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) chk (.*);
`default_nettype wire

//--- lpm_ctrl_bench.sv
// Self-checking bench for the low-power mode controller.
// Assumes a 100 MHz clock and a short settle count.
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_bench;
  localparam int SET = 4;
  logic clk, rst_n, wt, sp, fi, er, rr, fire, irq, phi, pe, osc, wk, slp, ecs_n, rcs_n;
  int err_count, checks_done;
  lpm_ctrl #(.SETTLE_CYC(SET)) dut (.clk_sys_i(clk), .arst_n_i(rst_n),
    .wait_instruction_i(wt), .stop_instruction_i(sp), .fetch_internal_i(fi),
    .ext_cs_req_i(er), .ram_cs_req_i(rr), .irq_pending_i(irq), .phi_o(phi),
    .periph_en_o(pe), .osc_run_o(osc), .wake_o(wk), .sleep_o(slp),
    .ext_cs_n_o(ecs_n), .ram_chip_select_n_o(rcs_n));
  lpm_irq_model irq_src (.clk_sys_i(clk), .arst_n_i(rst_n), .fire_i(fire),
    .wake_i(wk), .irq_pending_o(irq));
  task automatic chk(input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Raises an interrupt and counts cycles until wake-up, within a bound.
  task automatic wake_in(input int e);
    int n;
    n = 0;
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    do begin
      tick(1);
      n++;
    end while (wk !== 1'b1 && n < 50);
    if (n == 50) begin
      err_count++;
      end_of_test();
    end else begin
      chk(8'(e), 8'(n));
    end
  endtask
  task automatic t_cs;
    @(posedge clk) {fi, er, rr} <= 3'h3;
    tick(2);
    chk(8'h00, {6'h00, ecs_n, rcs_n});
    @(posedge clk) fi <= 1'b1;
    tick(2);
    chk(8'h03, {6'h00, ecs_n, rcs_n});
    $display("select test done");
  endtask
  task automatic t_wait;
    @(posedge clk) er <= 1'b0;
    tick(3);
    repeat (2) begin
      @(posedge clk) wt <= 1'b1;
      @(posedge clk) wt <= 1'b0;
      tick(2);
      chk(8'h17, {3'h0, slp, phi, pe, osc, ecs_n});
      wake_in(1);
    end
    $display("wait test done");
  endtask
  task automatic t_stop;
    @(posedge clk) sp <= 1'b1;
    @(posedge clk) sp <= 1'b0;
    tick(2);
    chk(8'h08, {4'h0, slp, phi, pe, osc});
    wake_in(SET + 1);
    $display("stop test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, wt, sp, fi, er, rr, fire} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_cs();
    t_wait();
    t_stop();
    end_of_test();
  end
endmodule
`default_nettype wire
